//--- verif/rca_top_chk.sv
// assertion checker for the calibration and alarm block ports
module rca_top_chk (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// apb side
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	// crystal and alarm side
	input  wire logic        xtal_tick,
	input  wire logic        alarm_irq,
	input  wire logic        alarm_pulse,
	input  wire logic        seconds_pulse
);
	logic       cfg_wr;
	logic       en_seen_d;
	logic       en_seen_q;
	logic [3:0] mask_d;
	logic [3:0] mask_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// shadow of the last alarm setup, since the checker cannot see inside
	always_comb
	begin
		cfg_wr    = psel && penable && pwrite && pready && (paddr == rca_pkg::OFF_ALM_CFG);
		en_seen_d = en_seen_q | (cfg_wr & pwdata[rca_pkg::ACFG_EN_BIT]);
		mask_d    = cfg_wr ? pwdata[rca_pkg::ACFG_MASK_LSB +: rca_pkg::MASK_W] : mask_q;
	end

	// register the shadow
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			en_seen_q <= 1'b0;
			mask_q    <= 4'h0;
		end
		else
		begin
			en_seen_q <= en_seen_d;
			mask_q    <= mask_d;
		end
	end

	chk_pulse_toggles: assert property (alarm_irq |-> alarm_pulse != $past(alarm_pulse))
		else $error("alarm pulse did not toggle on an event");
	chk_pulse_holds: assert property (!alarm_irq |-> $stable(alarm_pulse))
		else $error("alarm pulse moved without an event");
	chk_irq_single: assert property (alarm_irq |=> !alarm_irq)
		else $error("alarm event lasted two cycles");
	chk_irq_from_tick: assert property (alarm_irq |-> $past(xtal_tick, 2))
		else $error("alarm event without a crystal tick");
	chk_irq_needs_en: assert property (alarm_irq |-> en_seen_q)
		else $error("alarm event before the alarm was ever enabled");
	// masked digits fire at second start
	chk_mask_second: assert property (alarm_irq && mask_q != rca_pkg::AM_HALF |->
		$past(seconds_pulse))
		else $error("digit alarm not at a second boundary");
	chk_sec_from_tick: assert property (seconds_pulse |-> $past(xtal_tick))
		else $error("second pulse without a crystal tick");
	chk_sec_single: assert property (seconds_pulse |=> !seconds_pulse ##1 !seconds_pulse)
		else $error("second pulses too close together");
endmodule

bind rca_top rca_top_chk u_rca_top_chk (.clk_sys, .rst, .paddr, .psel, .penable, .pwrite,
	.pwdata, .prdata, .pready, .pslverr, .xtal_tick, .alarm_irq, .alarm_pulse, .seconds_pulse);

//--- verif/rca_top_tb_top.sv
// self-checking bench for the calibration and alarm block
module rca_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys;
	logic        rst;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        xtal_tick;
	logic        alarm_irq;
	logic        alarm_pulse;
	logic        seconds_pulse;
	int          miscompares;
	int          n_tests;
	int          n_irq;
	longint      cyc;
	longint      irq_at;
	longint      irq_prev;
	logic [31:0] rd;
	logic        err;
	logic [31:0] v;
	logic [7:0]  trim;
	logic        pv;
	logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
	logic [31:0] rstv [6] = '{32'h0, 32'h0, 32'h0, 32'h0, rca_pkg::TIME_RST, rca_pkg::DATE_RST};

	rca_top u_rca_top (.clk_sys, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .xtal_tick, .alarm_irq, .alarm_pulse, .seconds_pulse);

	// free-running clock, 10 ns
	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;

	// event log, so spacing is measured without racing the main sequence
	always @(posedge clk_sys)
	begin
		cyc++;
		if (alarm_irq === 1'b1)
		begin
			irq_prev = irq_at;
			irq_at   = cyc;
			n_irq++;
		end
	end

	function automatic logic [31:0] ctrl_w(input logic r, input logic u, input logic [7:0] t);
		return {16'h0, r, 1'b0, u, 5'h0, t};
	endfunction

	function automatic logic [31:0] cfg_w(input logic e, input logic c, input logic [3:0] m,
		input logic [7:0] r);
		return {16'h0, e, c, m, 2'h0, r};
	endfunction

	// interval between events once trim has acted on it
	function automatic logic [31:0] gap_exp(input int ticks, input logic [7:0] t);
		return 32'(ticks - int'($signed(t)));
	endfunction

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask

	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k >= 20)
		begin
			miscompares++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	// bounded wait for the next alarm event
	task automatic wait_irq(input int lim);
		int k;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (alarm_irq !== 1'b1 && k < lim);
		if (k >= lim)
		begin
			miscompares++;
			wrap_up();
		end
	endtask

	// main sequence
	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		xtal_tick = 1'b0;
		void'($urandom(62));
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		xtal_tick <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b0, offs[i], 32'h0);
			check("reset value", rstv[i], rd);
		end
		apb(1'b0, 8'h18, 32'h0);
		check("unmapped error", 32'h1, {31'h0, err});
		v = $urandom();
		apb(1'b1, rca_pkg::OFF_TIME, v);
		apb(1'b0, rca_pkg::OFF_TIME, 32'h0);
		check("locked time", rca_pkg::TIME_RST, rd);
		// trim from an error figure, set while stopped
		trim = 8'($urandom_range(100, 1));
		apb(1'b1, rca_pkg::OFF_CTRL, ctrl_w(1'b0, 1'b1, trim));
		apb(1'b1, rca_pkg::OFF_TIME, v);
		apb(1'b0, rca_pkg::OFF_TIME, 32'h0);
		check("unlocked time", v & rca_pkg::TIME_WMASK, rd);
		// alarm values written while the alarm is off
		apb(1'b1, rca_pkg::OFF_ALM_DATE, v);
		apb(1'b0, rca_pkg::OFF_ALM_DATE, 32'h0);
		check("alarm date", v & rca_pkg::DATE_WMASK & ~rca_pkg::CMP_YEAR_BITS, rd);
		apb(1'b1, rca_pkg::OFF_TIME, 32'h00000059);
		$display("test registers done");
		apb(1'b1, rca_pkg::OFF_ALM_CFG, cfg_w(1'b1, 1'b0, rca_pkg::AM_HALF, 8'h00));
		apb(1'b1, rca_pkg::OFF_CTRL, ctrl_w(1'b1, 1'b0, trim));
		pv = alarm_pulse;
		// crystal pauses a random while; the prescaler must count ticks only
		xtal_tick <= 1'b0;
		repeat ($urandom_range(8, 1)) @(posedge clk_sys);
		xtal_tick <= 1'b1;
		wait_irq(17000);
		check("pulse toggle", {31'h0, ~pv}, {31'h0, alarm_pulse});
		apb(1'b0, rca_pkg::OFF_ALM_CFG, 32'h0);
		check("single alarm", cfg_w(1'b0, 1'b0, rca_pkg::AM_HALF, 8'h00), rd);
		$display("test single alarm done");
		apb(1'b1, rca_pkg::OFF_ALM_CFG, cfg_w(1'b1, 1'b0, rca_pkg::AM_HALF, 8'h01));
		wait_irq(17000);
		apb(1'b0, rca_pkg::OFF_ALM_CFG, 32'h0);
		check("repeat decrement", cfg_w(1'b1, 1'b0, rca_pkg::AM_HALF, 8'h00), rd);
		wait_irq(17000);
		apb(1'b0, rca_pkg::OFF_ALM_CFG, 32'h0);
		check("last alarm off", cfg_w(1'b0, 1'b0, rca_pkg::AM_HALF, 8'h00), rd);
		check("positive trim gap", gap_exp(rca_pkg::XTAL_HZ / 2, trim), 32'(irq_at - irq_prev));
		check("event count", 32'd3, 32'(n_irq));
		$display("test repeat and positive trim done");
		trim = 8'(-$urandom_range(100, 1));
		apb(1'b1, rca_pkg::OFF_CTRL, ctrl_w(1'b0, 1'b1, trim));
		apb(1'b1, rca_pkg::OFF_TIME, 32'h00000159);
		apb(1'b1, rca_pkg::OFF_ALM_CFG, cfg_w(1'b1, 1'b1, rca_pkg::AM_SEC, 8'h00));
		apb(1'b1, rca_pkg::OFF_CTRL, ctrl_w(1'b1, 1'b0, trim));
		wait_irq(17000);
		apb(1'b0, rca_pkg::OFF_ALM_CFG, 32'h0);
		check("endless_repeat_bit wrap", cfg_w(1'b1, 1'b1, rca_pkg::AM_SEC, 8'hff), rd);
		wait_irq(33000);
		apb(1'b0, rca_pkg::OFF_ALM_CFG, 32'h0);
		check("count from ff", cfg_w(1'b1, 1'b1, rca_pkg::AM_SEC, 8'hfe), rd);
		check("negative trim gap", gap_exp(rca_pkg::XTAL_HZ, trim), 32'(irq_at - irq_prev));
		apb(1'b1, rca_pkg::OFF_ALM_CFG, 32'h0);
		$display("test endless_repeat_bit and negative trim done");
		wrap_up();
	end
endmodule

//--- verilog/rca_calendar.sv
// bcd time and calendar counter chain with software load
module rca_calendar (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// one pulse per elapsed second
	input  wire logic        sec_tick,
	// software loads
	input  wire logic        wr_time,
	input  wire logic        wr_date,
	input  wire logic [31:0] wdata,
	// current value
	output logic      [31:0] time_q,
	output logic      [31:0] date_q
);

	logic [31:0] time_d;
	logic [31:0] date_d;

	// bcd increment of a two-digit value
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9)
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		else
			bcd_inc = v + 8'h01;
	endfunction

	// last day of the month, leap years follow the year digits
	function automatic logic [5:0] day_last(input logic [4:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		if (mon == rca_pkg::MON_FEB)
			day_last = leap ? rca_pkg::DAY_29 : rca_pkg::DAY_28;
		else if (mon == rca_pkg::MON_APR || mon == rca_pkg::MON_JUN
			|| mon == rca_pkg::MON_SEP || mon == rca_pkg::MON_NOV)
			day_last = rca_pkg::DAY_30;
		else
			day_last = rca_pkg::DAY_31;
	endfunction

	// next value of the chain; a software load wins over the tick
	always_comb
	begin
		logic [6:0] sec;
		logic [6:0] min;
		logic [5:0] hr;
		logic [2:0] wd;
		logic [5:0] day;
		logic [4:0] mon;
		logic [7:0] yr;
		logic [7:0] t;
		sec = time_q[rca_pkg::SEC_LSB +: rca_pkg::SEC_W];
		min = time_q[rca_pkg::MIN_LSB +: rca_pkg::MIN_W];
		hr  = time_q[rca_pkg::HR_LSB +: rca_pkg::HR_W];
		wd  = date_q[rca_pkg::WDAY_LSB +: rca_pkg::WDAY_W];
		day = date_q[rca_pkg::DAY_LSB +: rca_pkg::DAY_W];
		mon = date_q[rca_pkg::MON_LSB +: rca_pkg::MON_W];
		yr  = date_q[rca_pkg::YR_LSB +: rca_pkg::YR_W];
		t   = 8'h00;
		if (sec_tick)
		begin
			if (sec != rca_pkg::SEC_LAST)
			begin
				t   = bcd_inc({1'b0, sec});
				sec = t[6:0];
			end
			else
			begin
				sec = '0;
				if (min != rca_pkg::MIN_LAST)
				begin
					t   = bcd_inc({1'b0, min});
					min = t[6:0];
				end
				else
				begin
					min = '0;
					if (hr != rca_pkg::HR_LAST)
					begin
						t  = bcd_inc({2'b00, hr});
						hr = t[5:0];
					end
					else
					begin
						// midnight: weekday and day move on, month and year only when they roll over
						hr = '0;
						wd = (wd == rca_pkg::WDAY_LAST) ? 3'h0 : wd + 3'h1;
						if (day != day_last(mon, yr))
						begin
							t   = bcd_inc({2'b00, day});
							day = t[5:0];
						end
						else
						begin
							day = rca_pkg::DAY_FIRST;
							if (mon != rca_pkg::MON_LAST)
							begin
								t   = bcd_inc({3'b000, mon});
								mon = t[4:0];
							end
							else
							begin
								mon = rca_pkg::MON_FIRST;
								yr  = (yr == rca_pkg::YR_LAST) ? 8'h00 : bcd_inc(yr);
							end
						end
					end
				end
			end
		end
		time_d = {10'h000, hr, 1'b0, min, 1'b0, sec};
		date_d = {yr, 3'h0, mon, 2'h0, day, 5'h00, wd};
		// unused bits are cut off so each digit keeps its own width
		if (wr_time)
			time_d = wdata & rca_pkg::TIME_WMASK;
		if (wr_date)
			date_d = wdata & rca_pkg::DATE_WMASK;
	end

	// chain registers
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			time_q <= rca_pkg::TIME_RST;
			date_q <= rca_pkg::DATE_RST;
		end
		else
		begin
			time_q <= time_d;
			date_q <= date_d;
		end
	end

endmodule

//--- verilog/rca_pkg.sv
// shared constants for the clock calibration and alarm block
package rca_pkg;

	// register byte offsets on the apb bus
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_ALM_CFG   = 8'h04;
	localparam logic [7:0] OFF_ALM_TIME  = 8'h08;
	localparam logic [7:0] OFF_ALM_DATE  = 8'h0c;
	localparam logic [7:0] OFF_TIME      = 8'h10;
	localparam logic [7:0] OFF_DATE      = 8'h14;

	// clock_config_trim_reg fields
	localparam int CTRL_RUN_BIT    = 15;
	localparam int CTRL_UNLOCK_BIT = 13;
	localparam int CTRL_SYNC_BIT   = 12;
	localparam int CTRL_HALF_BIT   = 11;
	localparam int TRIM_LSB        = 0;
	localparam int TRIM_W          = 8;

	// alarm_config_repeat_reg fields
	localparam int ACFG_EN_BIT    = 15;
	localparam int ACFG_ENDLESS_REPEAT_BIT_BIT = 14;
	localparam int ACFG_MASK_LSB  = 10;
	localparam int MASK_W         = 4;
	localparam int ACFG_RPT_LSB   = 0;
	localparam int RPT_W          = 8;
	localparam logic [7:0] RPT_MAX  = 8'hff;
	localparam logic [7:0] RPT_ZERO = 8'h00;

	// time word layout: hour, minute, second in bcd
	localparam int SEC_LSB  = 0;
	localparam int SEC_W    = 7;
	localparam int MIN_LSB  = 8;
	localparam int MIN_W    = 7;
	localparam int HR_LSB   = 16;
	localparam int HR_W     = 6;
	// date word layout: year, month, day, weekday
	localparam int WDAY_LSB = 0;
	localparam int WDAY_W   = 3;
	localparam int DAY_LSB  = 8;
	localparam int DAY_W    = 6;
	localparam int MON_LSB  = 16;
	localparam int MON_W    = 5;
	localparam int YR_LSB   = 24;
	localparam int YR_W     = 8;

	// writable bits of the time and date words, reset values
	localparam logic [31:0] TIME_WMASK = 32'h003f7f7f;
	localparam logic [31:0] DATE_WMASK = 32'hff1f3f07;
	localparam logic [31:0] TIME_RST   = 32'h00000000;
	localparam logic [31:0] DATE_RST   = 32'h00010100;

	// bcd limits of the calendar chain
	localparam logic [6:0] SEC_LAST   = 7'h59;
	localparam logic [6:0] MIN_LAST   = 7'h59;
	localparam logic [5:0] HR_LAST    = 6'h23;
	localparam logic [2:0] WDAY_LAST  = 3'h6;
	localparam logic [4:0] MON_LAST   = 5'h12;
	localparam logic [7:0] YR_LAST    = 8'h99;
	localparam logic [5:0] DAY_FIRST  = 6'h01;
	localparam logic [4:0] MON_FIRST  = 5'h01;
	localparam logic [4:0] MON_FEB    = 5'h02;
	localparam logic [4:0] MON_APR    = 5'h04;
	localparam logic [4:0] MON_JUN    = 5'h06;
	localparam logic [4:0] MON_SEP    = 5'h09;
	localparam logic [4:0] MON_NOV    = 5'h11;
	localparam logic [5:0] DAY_28     = 6'h28;
	localparam logic [5:0] DAY_29     = 6'h29;
	localparam logic [5:0] DAY_30     = 6'h30;
	localparam logic [5:0] DAY_31     = 6'h31;

	// crystal prescaler: 32768 crystal pulses per second
	localparam int XTAL_HZ          = 32768;
	localparam int PRE_W            = 15;
	localparam int HALF_BIT         = 14;
	localparam logic [14:0] SYNC_START = 15'h7fe0;
	localparam logic [1:0] INC_NONE = 2'h0;
	localparam logic [1:0] INC_ONE  = 2'h1;
	localparam logic [1:0] INC_TWO  = 2'h2;

	// trim is applied at each quarter minute, four times a minute
	localparam logic [6:0] SEC_Q0 = 7'h00;
	localparam logic [6:0] SEC_Q1 = 7'h15;
	localparam logic [6:0] SEC_Q2 = 7'h30;
	localparam logic [6:0] SEC_Q3 = 7'h45;

	// alarm_digit_mask codes
	localparam logic [3:0] AM_HALF  = 4'h0;
	localparam logic [3:0] AM_SEC   = 4'h1;
	localparam logic [3:0] AM_10S   = 4'h2;
	localparam logic [3:0] AM_MIN   = 4'h3;
	localparam logic [3:0] AM_10M   = 4'h4;
	localparam logic [3:0] AM_HOUR  = 4'h5;
	localparam logic [3:0] AM_DAY   = 4'h6;
	localparam logic [3:0] AM_WEEK  = 4'h7;
	localparam logic [3:0] AM_MONTH = 4'h8;
	localparam logic [3:0] AM_YEAR  = 4'h9;

	// digit masks used by the alarm comparison
	localparam logic [31:0] CMP_NONE  = 32'h00000000;
	localparam logic [31:0] CMP_SEC1  = 32'h0000000f;
	localparam logic [31:0] CMP_SEC   = 32'h0000007f;
	localparam logic [31:0] CMP_MIN1  = 32'h00000f7f;
	localparam logic [31:0] CMP_MIN   = 32'h00007f7f;
	localparam logic [31:0] CMP_HOUR  = 32'h003f7f7f;
	localparam logic [31:0] CMP_WDAY  = 32'h00000007;
	localparam logic [31:0] CMP_MDAY  = 32'h00003f00;
	localparam logic [31:0] CMP_YDAY  = 32'h001f3f00;
	// year digits of the alarm date word are never stored and read as zero
	localparam logic [31:0] CMP_YEAR_BITS = 32'hff000000;

	// calibration state
	typedef enum logic [1:0] {CAL_IDLE, CAL_SWALLOW, CAL_INSERT} rca_cal_e;

endpackage

//--- verilog/rca_top.sv
// clock calibration and alarm block with apb register access
//
// Function
// - trim times four pulses corrected per minute
// - negative trim removes crystal pulses
// - positive trim adds crystal pulses
// - adjustment happens at 15-second boundaries
// - alarm runs only while enable set
// - hardware clears enable after final alarm
// - digit mask selects compared time digits
// - zero repeat without endless_repeat_bit: single alarm
// - repeat count ff gives 255 repeats
// - count decrements; at zero one more, off
// - endless_repeat_bit wraps count to ff endlessly
// - each alarm event raises interrupt request
// - alarm pulse toggles each alarm event
// - time registers hold bcd digits
// - time writes need write unlock set
//
// Implementation choices: register access over APB and the register offsets.
module rca_top (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// one pulse per 32.768 khz crystal period
	input  wire logic        xtal_tick,
	// alarm and seconds outputs
	output logic             alarm_irq,
	output logic             alarm_pulse,
	output logic             seconds_pulse
);

	// prescaler and calibration state
	logic [14:0]        pre_q;
	logic [14:0]        pre_d;
	logic [7:0]         adj_q;
	logic [7:0]         adj_d;
	rca_pkg::rca_cal_e  cal_q;
	rca_pkg::rca_cal_e  cal_d;
	logic               half_tick;
	logic               sec_tick;
	logic               eval_q;
	logic               sec_eval_q;
	logic               half_ph_q;

	// software visible control
	logic               run_q;
	logic               run_d;
	logic               unlock_q;
	logic               unlock_d;
	logic [7:0]         trim_q;
	logic [7:0]         trim_d;

	// alarm configuration and state
	logic               aen_q;
	logic               aen_d;
	logic               endless_repeat_bit_q;
	logic               endless_repeat_bit_d;
	logic [3:0]         alarm_digit_mask_q;
	logic [3:0]         alarm_digit_mask_d;
	logic [7:0]         alarm_repeat_count_q;
	logic [7:0]         alarm_repeat_count_d;
	logic [31:0]        atime_q;
	logic [31:0]        atime_d;
	logic [31:0]        adate_q;
	logic [31:0]        adate_d;
	logic               apulse_q;
	logic               apulse_d;
	logic               irq_q;
	logic               irq_d;

	// bus side
	logic [31:0]        rdata_q;
	logic [31:0]        rdata_d;
	logic               err_q;
	logic               err_d;
	logic               wr_en;
	logic               alarm_hit;
	logic               sync_flag;
	logic [31:0]        time_w;
	logic [31:0]        date_w;
	logic [31:0]        ctrl_w;
	logic [31:0]        acfg_w;

	// address decode, shared by read and write paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = hit(a, rca_pkg::OFF_CTRL) || hit(a, rca_pkg::OFF_ALM_CFG)
			|| hit(a, rca_pkg::OFF_ALM_TIME) || hit(a, rca_pkg::OFF_ALM_DATE)
			|| hit(a, rca_pkg::OFF_TIME) || hit(a, rca_pkg::OFF_DATE);
	endfunction

	// masked digit comparison; codes above a year never match
	function automatic logic digits_match(
		input logic [3:0]  m,
		input logic        half,
		input logic [31:0] t,
		input logic [31:0] d,
		input logic [31:0] at,
		input logic [31:0] ad
	);
		logic [31:0] tm;
		logic [31:0] dm;
		logic        ok;
		tm = rca_pkg::CMP_NONE;
		dm = rca_pkg::CMP_NONE;
		ok = 1'b1;
		unique case (m)
			rca_pkg::AM_HALF:  ok = 1'b1;
			rca_pkg::AM_SEC:   tm = rca_pkg::CMP_NONE;
			rca_pkg::AM_10S:   tm = rca_pkg::CMP_SEC1;
			rca_pkg::AM_MIN:   tm = rca_pkg::CMP_SEC;
			rca_pkg::AM_10M:   tm = rca_pkg::CMP_MIN1;
			rca_pkg::AM_HOUR:  tm = rca_pkg::CMP_MIN;
			rca_pkg::AM_DAY:   tm = rca_pkg::CMP_HOUR;
			rca_pkg::AM_WEEK:
			begin
				tm = rca_pkg::CMP_HOUR;
				dm = rca_pkg::CMP_WDAY;
			end
			rca_pkg::AM_MONTH:
			begin
				tm = rca_pkg::CMP_HOUR;
				dm = rca_pkg::CMP_MDAY;
			end
			rca_pkg::AM_YEAR:
			begin
				tm = rca_pkg::CMP_HOUR;
				dm = rca_pkg::CMP_YDAY;
			end
			default:           ok = 1'b0;
		endcase
		// everything but the half-second code fires on the whole second only
		if (m != rca_pkg::AM_HALF && half)
			ok = 1'b0;
		digits_match = ok && (((t ^ at) & tm) == '0) && (((d ^ ad) & dm) == '0);
	endfunction

	// time and calendar chain
	// unlock gates time writes
	rca_calendar u_calendar (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.sec_tick (sec_tick),
		.wr_time  (wr_en && hit(paddr, rca_pkg::OFF_TIME) && unlock_q),
		.wr_date  (wr_en && hit(paddr, rca_pkg::OFF_DATE) && unlock_q),
		.wdata    (pwdata),
		.time_q   (time_w),
		.date_q   (date_w)
	);

	// prescaler and trim, the wide carry bit marks the second
	always_comb
	begin
		logic [15:0] sum;
		logic [1:0]  inc;
		logic [6:0]  sec;
		inc   = inc_sel(xtal_tick, run_q, cal_q);
		sum   = {1'b0, pre_q} + {14'h0000, inc};
		pre_d = sum[14:0];
		adj_d = adj_q;
		cal_d = cal_q;
		sec   = time_w[rca_pkg::SEC_LSB +: rca_pkg::SEC_W];
		half_tick = sum[rca_pkg::HALF_BIT] ^ pre_q[rca_pkg::HALF_BIT];
		sec_tick  = sum[rca_pkg::PRE_W];
		// each corrected crystal pulse uses up one unit of the load
		if (cal_q != rca_pkg::CAL_IDLE && xtal_tick && run_q)
		begin
			adj_d = adj_q - 8'h01;
			if (adj_q == 8'h01)
				cal_d = rca_pkg::CAL_IDLE;
		end
		if (sec_eval_q && run_q && (sec == rca_pkg::SEC_Q0 || sec == rca_pkg::SEC_Q1
			|| sec == rca_pkg::SEC_Q2 || sec == rca_pkg::SEC_Q3))
		begin
			adj_d = trim_q[7] ? 8'h00 - trim_q : trim_q;
			if (trim_q == 8'h00)
				cal_d = rca_pkg::CAL_IDLE;
			else if (trim_q[7])
				cal_d = rca_pkg::CAL_SWALLOW;
			else
				cal_d = rca_pkg::CAL_INSERT;
		end
	end

	// crystal pulses count one, none or two depending on the correction
	function automatic logic [1:0] inc_sel(
		input logic              tick,
		input logic              run,
		input rca_pkg::rca_cal_e cal
	);
		if (!tick || !run)
			inc_sel = rca_pkg::INC_NONE;
		else if (cal == rca_pkg::CAL_SWALLOW)
			inc_sel = rca_pkg::INC_NONE;
		else if (cal == rca_pkg::CAL_INSERT)
			inc_sel = rca_pkg::INC_TWO;
		else
			inc_sel = rca_pkg::INC_ONE;
	endfunction

	// prescaler registers; the compare runs a cycle after the time update
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pre_q      <= '0;
			adj_q      <= '0;
			cal_q      <= rca_pkg::CAL_IDLE;
			eval_q     <= 1'b0;
			sec_eval_q <= 1'b0;
			half_ph_q  <= 1'b0;
		end
		else
		begin
			pre_q      <= pre_d;
			adj_q      <= adj_d;
			cal_q      <= cal_d;
			eval_q     <= half_tick;
			sec_eval_q <= sec_tick;
			if (half_tick)
				half_ph_q <= pre_d[rca_pkg::HALF_BIT];
		end
	end

	// a rollover is close: last 32 crystal pulses of the second
	assign sync_flag = (pre_q >= rca_pkg::SYNC_START);
	assign wr_en     = psel && penable && pwrite;

	// control and alarm next state
	always_comb
	begin
		run_d    = run_q;
		unlock_d = unlock_q;
		trim_d   = trim_q;
		aen_d    = aen_q;
		endless_repeat_bit_d  = endless_repeat_bit_q;
		alarm_digit_mask_d  = alarm_digit_mask_q;
		alarm_repeat_count_d   = alarm_repeat_count_q;
		atime_d  = atime_q;
		adate_d  = adate_q;
		apulse_d = apulse_q;
		irq_d    = 1'b0;
		alarm_hit = eval_q && aen_q
			&& digits_match(alarm_digit_mask_q, half_ph_q, time_w, date_w, atime_q, adate_q);
		if (alarm_hit)
		begin
			irq_d = 1'b1;
			apulse_d = ~apulse_q;
			if (alarm_repeat_count_q == rca_pkg::RPT_ZERO)
			begin
				if (endless_repeat_bit_q)
					alarm_repeat_count_d = rca_pkg::RPT_MAX;
				else
					aen_d = 1'b0;
			end
			else
				alarm_repeat_count_d = alarm_repeat_count_q - 8'h01;
		end
		// software writes land after the alarm update and so win
		if (wr_en && hit(paddr, rca_pkg::OFF_CTRL))
		begin
			run_d    = pwdata[rca_pkg::CTRL_RUN_BIT];
			unlock_d = pwdata[rca_pkg::CTRL_UNLOCK_BIT];
			trim_d   = pwdata[rca_pkg::TRIM_LSB +: rca_pkg::TRIM_W];
		end
		if (wr_en && hit(paddr, rca_pkg::OFF_ALM_CFG))
		begin
			aen_d   = pwdata[rca_pkg::ACFG_EN_BIT];
			endless_repeat_bit_d = pwdata[rca_pkg::ACFG_ENDLESS_REPEAT_BIT_BIT];
			alarm_digit_mask_d = pwdata[rca_pkg::ACFG_MASK_LSB +: rca_pkg::MASK_W];
			alarm_repeat_count_d  = pwdata[rca_pkg::ACFG_RPT_LSB +: rca_pkg::RPT_W];
		end
		if (wr_en && hit(paddr, rca_pkg::OFF_ALM_TIME))
			atime_d = pwdata & rca_pkg::TIME_WMASK;
		if (wr_en && hit(paddr, rca_pkg::OFF_ALM_DATE))
			adate_d = pwdata & rca_pkg::DATE_WMASK & ~rca_pkg::CMP_YEAR_BITS;
	end

	// control and alarm registers
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			run_q    <= 1'b0;
			unlock_q <= 1'b0;
			trim_q   <= '0;
			aen_q    <= 1'b0;
			endless_repeat_bit_q  <= 1'b0;
			alarm_digit_mask_q  <= '0;
			alarm_repeat_count_q   <= '0;
			atime_q  <= '0;
			adate_q  <= '0;
			apulse_q <= 1'b0;
			irq_q    <= 1'b0;
		end
		else
		begin
			run_q    <= run_d;
			unlock_q <= unlock_d;
			trim_q   <= trim_d;
			aen_q    <= aen_d;
			endless_repeat_bit_q  <= endless_repeat_bit_d;
			alarm_digit_mask_q  <= alarm_digit_mask_d;
			alarm_repeat_count_q   <= alarm_repeat_count_d;
			atime_q  <= atime_d;
			adate_q  <= adate_d;
			apulse_q <= apulse_d;
			irq_q    <= irq_d;
		end
	end

	// read views of the two configuration words
	always_comb
	begin
		ctrl_w = '0;
		ctrl_w[rca_pkg::CTRL_RUN_BIT]    = run_q;
		ctrl_w[rca_pkg::CTRL_UNLOCK_BIT] = unlock_q;
		ctrl_w[rca_pkg::CTRL_SYNC_BIT]   = sync_flag;
		ctrl_w[rca_pkg::CTRL_HALF_BIT]   = pre_q[rca_pkg::HALF_BIT];
		ctrl_w[rca_pkg::TRIM_LSB +: rca_pkg::TRIM_W] = trim_q;
		acfg_w = '0;
		acfg_w[rca_pkg::ACFG_EN_BIT]    = aen_q;
		acfg_w[rca_pkg::ACFG_ENDLESS_REPEAT_BIT_BIT] = endless_repeat_bit_q;
		acfg_w[rca_pkg::ACFG_MASK_LSB +: rca_pkg::MASK_W] = alarm_digit_mask_q;
		acfg_w[rca_pkg::ACFG_RPT_LSB +: rca_pkg::RPT_W]   = alarm_repeat_count_q;
	end

	// read data captured in the setup cycle, held through the access
	always_comb
	begin
		rdata_d = rdata_q;
		err_d   = err_q;
		if (psel && !penable)
		begin
			err_d = !mapped(paddr);
			if (pwrite)
				rdata_d = '0;
			else if (hit(paddr, rca_pkg::OFF_CTRL))
				rdata_d = ctrl_w;
			else if (hit(paddr, rca_pkg::OFF_ALM_CFG))
				rdata_d = acfg_w;
			else if (hit(paddr, rca_pkg::OFF_ALM_TIME))
				rdata_d = atime_q;
			else if (hit(paddr, rca_pkg::OFF_ALM_DATE))
				rdata_d = adate_q;
			else if (hit(paddr, rca_pkg::OFF_TIME))
				rdata_d = time_w;
			else if (hit(paddr, rca_pkg::OFF_DATE))
				rdata_d = date_w;
			else
				rdata_d = '0;
		end
	end

	// bus registers
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			rdata_q <= '0;
			err_q   <= 1'b0;
		end
		else
		begin
			rdata_q <= rdata_d;
			err_q   <= err_d;
		end
	end

	// zero wait states; the error flag is only shown in the access phase
	assign pready        = 1'b1;
	assign pslverr       = psel && penable && err_q;
	assign prdata        = rdata_q;
	assign alarm_irq     = irq_q;
	assign alarm_pulse   = apulse_q;
	assign seconds_pulse = sec_eval_q;

endmodule
